// ---- lcd_display_memory_driver.sv ----
// Purpose: Display memory in bank 1 plus autonomous common/segment scanner.
// Assumes: Core gives address, indirect flag, write strobe; options are static straps.
// Notes:   Drive levels are two-bit codes for an external analogue level switch.
`timescale 1ns/10ps
`default_nettype none
module lcd_display_memory_driver
    import lcd_mem_pkg::*;
(
    input  wire logic                 clk_sys_in,        // Option-selected source clock
    input  wire logic                 srst_in,           // Synchronous reset, high
    input  wire logic [7:0]           mem_addr_in,       // Data-memory address
    input  wire logic                 mem_indirect_in,   // Access via indirect_pointer_one
    input  wire logic                 mem_wr_in,         // Write strobe
    input  wire logic                 mem_rd_in,         // Read strobe
    input  wire logic [7:0]           mem_wdata_in,      // Write data
    output logic      [7:0]           mem_rdata_out,     // Read data, registered
    output logic                      mem_hit_out,       // Access claimed by this block
    input  wire logic [1:0]           opt_commons_in,    // Common count option
    input  wire logic                 opt_third_bias_in, // 1 = one-third bias
    input  wire logic                 opt_cap_bias_in,   // 1 = capacitor bias
    input  wire logic [2:0]           opt_div_in,        // 0..6 selects 2^2..2^8
    input  wire logic                 opt_halt_run_in,   // 1 = keep running in sleep
    input  wire logic                 sleep_in,          // Core in sleep_instruction_state
    output logic      [3:0][1:0]      common_level_out,  // Common drive levels
    output logic      [14:0][1:0]     segment_level_out, // Segment drive levels
    output logic                      cap_pump_en_out,   // Capacitor bias pump enable
    output logic                      driver_on_out      // Driver active
);
    import lcd_mem_pkg::*;

    logic [7:0] bank_ptr_q;                   // memory_bank_pointer
    logic [7:0] disp_mem_q [SEG_LINES];       // Display memory
    logic [7:0] prescale_q;                   // Driver clock divider
    logic [1:0] com_q;                        // Active common slot
    phase_t     phase_q;                      // Frame polarity half
    logic       tick_q;                       // Registered driver tick

    // Address decode
    wire bank_sel   = (mem_addr_in == BANK_PTR_ADDR);
    wire in_window  = (mem_addr_in >= DISP_FIRST_ADDR) && (mem_addr_in <= DISP_LAST_ADDR);
    wire disp_sel   = in_window && (bank_ptr_q == BANK_DISP) && mem_indirect_in;
    wire [3:0] disp_idx = 4'(mem_addr_in - DISP_FIRST_ADDR);
    assign mem_hit_out = disp_sel || bank_sel;

    // Run gating in sleep
    wire run = !(sleep_in && !opt_halt_run_in);
    assign driver_on_out = run;
    assign cap_pump_en_out = run && opt_cap_bias_in;

    // Common count, last slot index
    wire [1:0] last_com = (opt_commons_in == COMMONS_FOUR)  ? 2'h3 :
                          (opt_commons_in == COMMONS_THREE) ? 2'h2 : 2'h1;

    // Divider mask: low (2+sel) prescaler bits all ones once per 2^(2+sel) cycles
    // Codes above the last option fall back to the slowest rate
    wire [2:0] div_sel  = (opt_div_in > DIV_SEL_MAX) ? DIV_SEL_MAX : opt_div_in;
    // Nine bits so the divide-by-256 span does not wrap to zero
    wire [8:0] div_span = 9'h004 << div_sel;
    wire [7:0] div_mask = 8'(div_span - 9'h001);
    wire       div_tick = ((prescale_q & div_mask) == div_mask) && run;

    // Register writes and bank pointer
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            bank_ptr_q <= BANK_PTR_RESET;
        end else if (mem_wr_in && bank_sel) begin
            bank_ptr_q <= mem_wdata_in;
        end
    end

    // Display memory holds value; scanning never writes it
    always_ff @(posedge clk_sys_in) begin
        if (mem_wr_in && disp_sel) begin
            disp_mem_q[disp_idx] <= mem_wdata_in;
        end
    end

    // Read mux, registered
    // Bank pointer reads back too, so firmware can save and restore it
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            mem_rdata_out <= 8'h00;
        end else if (mem_rd_in && disp_sel) begin
            mem_rdata_out <= disp_mem_q[disp_idx];
        end else if (mem_rd_in && bank_sel) begin
            mem_rdata_out <= bank_ptr_q;
        end
    end

    // Prescaler and scan counter
    // Stopping in sleep parks the scan at slot zero for a clean restart
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || !run) begin
            prescale_q <= 8'h00;
            com_q      <= 2'h0;
            phase_q    <= PH_POS;
            tick_q     <= 1'b0;
        end else begin
            prescale_q <= prescale_q + 8'h01;
            tick_q     <= div_tick;
            if (div_tick) begin
                phase_q <= (phase_q == PH_POS) ? PH_NEG : PH_POS;
                if (phase_q == PH_NEG) begin
                    com_q <= (com_q >= last_com) ? 2'h0 : com_q + 2'h1;
                end
            end
        end
    end

    // Level encodings per bias
    wire [1:0] lv_sel_on  = (phase_q == PH_POS) ? 2'h3 : 2'h0; // Selected common
    wire [1:0] lv_sel_off = opt_third_bias_in ?
                            ((phase_q == PH_POS) ? 2'h1 : 2'h2) : 2'h1;
    wire [1:0] seg_on     = (phase_q == PH_POS) ? 2'h0 : 2'h3;
    wire [1:0] seg_off    = opt_third_bias_in ?
                            ((phase_q == PH_POS) ? 2'h2 : 2'h1) : lv_sel_on;
    wire       four_com   = (opt_commons_in == COMMONS_FOUR);

    // Output drive
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || !run) begin
            common_level_out  <= '0;
            segment_level_out <= '0;
        end else begin
            // Commons past the last slot sit at ground, so no stray field builds up
            for (int c = 0; c < 4; c++) begin
                if (c[1:0] > last_com) begin
                    common_level_out[c] <= 2'h0;
                end else if (c[1:0] == com_q) begin
                    common_level_out[c] <= lv_sel_on;
                end else begin
                    common_level_out[c] <= lv_sel_off;
                end
            end
            // Bits above the active commons are never looked at
            for (int s = 0; s < SEG_LINES; s++) begin
                if (four_com && s == SEG_LINES - 1) begin
                    segment_level_out[s] <= 2'h0;
                end else if (disp_mem_q[s][com_q]) begin
                    segment_level_out[s] <= seg_on;
                end else begin
                    segment_level_out[s] <= seg_off;
                end
            end
        end
    end

    // Bank pointer routes only indirect window accesses
    property p_window_route;
        @(posedge clk_sys_in) disable iff (srst_in)
        mem_hit_out && in_window |-> (bank_ptr_q == BANK_DISP) && mem_indirect_in;
    endproperty
    a_window_route: assert property (p_window_route) else $error("bad route");

    // Written byte reads back next cycle
    property p_readback;
        @(posedge clk_sys_in) disable iff (srst_in)
        mem_wr_in && disp_sel ##1 mem_rd_in && disp_sel &&
        mem_addr_in == $past(mem_addr_in) |=> mem_rdata_out == $past(mem_wdata_in, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("readback");

    // Scan stays within selected commons
    property p_com_range;
        @(posedge clk_sys_in) disable iff (srst_in)
        opt_commons_in == $past(opt_commons_in) |-> com_q <= last_com || !$past(run);
    endproperty
    a_com_range: assert property (p_com_range) else $error("com range");

    // Sleep with off option holds common outputs low
    property p_sleep_off;
        @(posedge clk_sys_in) disable iff (srst_in)
        !run |=> common_level_out == '0;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep");

    // A display write lands in the addressed byte
    property p_write_lands;
        @(posedge clk_sys_in) disable iff (srst_in)
        mem_wr_in && disp_sel |=> disp_mem_q[$past(disp_idx)] == $past(mem_wdata_in);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write lost");

    // Window writes that are direct or in bank 0 leave display bytes alone
    property p_gp_untouched;
        @(posedge clk_sys_in) disable iff (srst_in)
        mem_wr_in && in_window && !disp_sel |=>
            disp_mem_q[$past(disp_idx)] == $past(disp_mem_q[disp_idx]);
    endproperty
    a_gp_untouched: assert property (p_gp_untouched) else $error("byte disturbed");

    // Quarter duty hands the last segment pin over to the fourth common
    property p_shared_pin;
        @(posedge clk_sys_in) disable iff (srst_in)
        four_com |=> segment_level_out[SEG_LINES - 1] == 2'h0;
    endproperty
    a_shared_pin: assert property (p_shared_pin) else $error("shared pin driven");

    // Every divider tick flips the frame polarity
    property p_tick_phase;
        @(posedge clk_sys_in) disable iff (srst_in)
        tick_q |-> phase_q != $past(phase_q);
    endproperty
    a_tick_phase: assert property (p_tick_phase) else $error("phase stuck");
endmodule
`default_nettype wire

// ---- lcd_mem_pkg.sv ----
// Purpose: Shared constants for the segment LCD display memory and driver.
// Assumes: Byte-wide data memory bus on the core side, one clock.
// Notes:   Offsets are data-memory addresses; counts are display bytes and segment lines.
package lcd_mem_pkg;
    localparam logic [7:0] BANK_PTR_ADDR   = 8'h04; // Bank pointer location
    localparam logic [7:0] DISP_FIRST_ADDR = 8'h40; // First display byte
    localparam logic [7:0] DISP_LAST_ADDR  = 8'h4e; // Last display byte
    localparam logic [7:0] BANK_GP         = 8'h00; // General-purpose bank
    localparam logic [7:0] BANK_DISP       = 8'h01; // Display bank
    localparam logic [7:0] BANK_PTR_RESET  = 8'h00; // Bank pointer after reset
    localparam int         SEG_LINES       = 15;    // Display bytes / segment lines
    localparam logic [2:0] DIV_SEL_MIN     = 3'h0;  // Option code for divide by 2^2
    localparam logic [2:0] DIV_SEL_MAX     = 3'h6;  // Option code for divide by 2^8
    localparam logic [1:0] COMMONS_TWO     = 2'h0;  // Half duty
    localparam logic [1:0] COMMONS_THREE   = 2'h1;  // One-third duty
    localparam logic [1:0] COMMONS_FOUR    = 2'h2;  // Quarter duty
    // Drive level codes: 0 = ground, 1..2 intermediate, 3 = full VLCD
    typedef enum logic [1:0] {
        LVL_GND  = 2'h0,
        LVL_LOW  = 2'h1,
        LVL_HIGH = 2'h2,
        LVL_TOP  = 2'h3
    } level_t;
    // Scan phases of one common slot, Gray coded
    typedef enum logic [0:0] {
        PH_POS = 1'b0,
        PH_NEG = 1'b1
    } phase_t;
endpackage

// ---- lcd_glass_model.sv ----
// Purpose: Segment glass model that records which cells have been lit.
// Assumes: A cell lights only when its common and segment sit full swing apart.
// Notes:   lit_out accumulates; clear_in wipes the history.
`timescale 1ns/10ps
`default_nettype none
module lcd_glass_model (
    input  wire logic             clk_sys_in, // Source clock
    input  wire logic             clear_in,   // Wipe lit history
    input  wire logic [3:0][1:0]  common_in,  // Common drive levels
    input  wire logic [14:0][1:0] segment_in, // Segment drive levels
    output logic      [14:0]      lit_out     // Cells seen lit
);
    logic [14:0] hit_now; // Full swing on any common now
    // Only the extreme levels light a cell, so bias steps cannot fake one
    always_comb begin
        hit_now = '0;
        for (int k = 0; k < 15; k++) begin
            for (int n = 0; n < 4; n++) begin
                if ({common_in[n], segment_in[k]} inside {4'hc, 4'h3}) hit_now[k] = 1'b1;
            end
        end
    end
    // Sticky record, so a slow scan is still caught
    always_ff @(posedge clk_sys_in) lit_out <= clear_in ? '0 : (lit_out | hit_now);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for display memory and scanner.
// Assumes: Inputs change on the falling edge; read data one edge after a read.
// Notes:   Reads queue their expected byte; a monitor pops and compares.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import lcd_mem_pkg::*;
    logic clk_sys_in = 0, srst_in = 1, ind = 0, wr = 0, rd = 0, clr = 0;
    logic slp = 0, run = 1, cap = 0, tb3 = 0, rd_seen = 0, moved, c2, c3, s14, mid2;
    logic [7:0]  addr = 0, wdata = 0, rdata, d [15];
    logic [1:0]  com = COMMONS_TWO;
    logic [2:0]  div = 0;
    logic        hit, pump, on;
    logic [3:0][1:0]  coml, com_prev; // Common levels and their one-edge-late copy
    logic [14:0][1:0] segl, seg_prev;
    logic [14:0] lit;
    logic [7:0]  q [$]; // Expected read bytes
    int fails = 0, n_checks = 0, seed = 14100, cyc = 0;
    int gap = 0, gap_run = 0; // Cycles between common level changes
    lcd_display_memory_driver dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .mem_addr_in(addr), .mem_indirect_in(ind), .mem_wr_in(wr), .mem_rd_in(rd),
        .mem_wdata_in(wdata), .mem_rdata_out(rdata), .mem_hit_out(hit),
        .opt_commons_in(com), .opt_third_bias_in(tb3), .opt_cap_bias_in(cap),
        .opt_div_in(div), .opt_halt_run_in(run), .sleep_in(slp),
        .common_level_out(coml), .segment_level_out(segl),
        .cap_pump_en_out(pump), .driver_on_out(on));
    lcd_glass_model glass (.clk_sys_in(clk_sys_in), .clear_in(clr), .common_in(coml),
        .segment_in(segl), .lit_out(lit));
    initial forever #50 clk_sys_in = ~clk_sys_in;
    task automatic report_and_stop();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // One access per call; a read carries its expected byte in v
    task automatic acc(input logic [7:0] a, input logic i, w, r, input logic [7:0] v, h);
        @(negedge clk_sys_in);
        {addr, ind, wr, rd, wdata} = {a, i, w, r, v};
        #1 chk(16'(h), 16'(hit));
        if (r && h) q.push_back(v);
    endtask
    task automatic idle(input int n);
        @(negedge clk_sys_in);
        {wr, rd} = 2'b00;
        repeat (n) @(negedge clk_sys_in);
    endtask
    // Fresh watch window for glass and scanner flags
    task automatic watch(input int n);
        idle(1); clr = 1; idle(1); clr = 0; idle(n);
    endtask
    // Read data monitor and hang guard
    always @(posedge clk_sys_in) begin
        if (rd_seen) chk(16'(q.pop_front()), 16'(rdata));
        rd_seen <= rd && hit;
        cyc <= cyc + 1;
        if (cyc > 60000) begin
            fails++;
            report_and_stop();
        end
    end
    // Scanner activity flags, cleared with the glass
    always @(posedge clk_sys_in) begin
        seg_prev <= segl;
        com_prev <= coml;
        // Every divider tick moves some common level, so the gap is the tick period
        gap_run  <= (coml != com_prev) ? 0 : gap_run + 1;
        if (coml != com_prev) gap <= gap_run + 1;
        if (clr) {moved, c2, c3, s14, mid2} <= 5'b00000;
        else {moved, c2, c3, s14, mid2} <= {moved | (segl != seg_prev), c2 | (coml[2] != 2'h0),
                                            c3 | (coml[3] != 2'h0), s14 | (segl[14] != 2'h0),
                                            mid2 | (coml[0] == 2'h2) | (coml[1] == 2'h2)};
    end
    initial begin
        div = 3'($unsigned($random(seed)) % 7);
        tb3 = 1'($random(seed));
        repeat (12) @(negedge clk_sys_in);
        srst_in = 0;
        acc(BANK_PTR_ADDR, 0, 1, 0, BANK_DISP, 1);
        for (int k = 0; k < 15; k++) begin
            d[k] = 8'($random(seed));
            acc(DISP_FIRST_ADDR + 8'(k), 1, 1, 0, d[k], 1);
        end
        for (int k = 0; k < 15; k++) acc(DISP_FIRST_ADDR + 8'(k), 1, 0, 1, d[k], 1);
        acc(BANK_PTR_ADDR, 0, 0, 1, BANK_DISP, 1);
        acc(BANK_PTR_ADDR, 0, 1, 0, BANK_GP, 1);
        acc(DISP_FIRST_ADDR, 1, 1, 0, 8'h5a, 0);
        acc(BANK_PTR_ADDR, 0, 1, 0, BANK_DISP, 1);
        acc(DISP_FIRST_ADDR + 8'h01, 0, 1, 0, 8'ha5, 0);
        acc(DISP_LAST_ADDR + 8'h01, 1, 1, 0, 8'h00, 0);
        acc(DISP_FIRST_ADDR, 1, 0, 1, d[0], 1);
        acc(DISP_FIRST_ADDR + 8'h01, 1, 0, 1, d[1], 1);
        // Write then read the same byte back to back
        acc(DISP_FIRST_ADDR + 8'h02, 1, 1, 0, 8'h3c, 1);
        acc(DISP_FIRST_ADDR + 8'h02, 1, 0, 1, 8'h3c, 1);
        watch(2100);
        chk(16'h1, 16'(moved));
        chk(16'h0, 16'(c2));
        chk(16'(tb3), 16'(mid2));
        chk(16'(32'h4 << div), 16'(gap));
        com = COMMONS_THREE;
        watch(3200);
        chk(16'h1, 16'(c2));
        chk(16'h0, 16'(c3));
        com = COMMONS_FOUR;
        // Bit 3 only, so each cell but the last (its segment held at ground) can light in the fourth common slot alone
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 15; k++) begin
                acc(DISP_FIRST_ADDR + 8'(k), 1, 1, 0, 8'(p * 8), 1);
            end
            watch(4200);
            chk(16'(p ? 14'h3fff : 14'h0), 16'(lit[13:0]));
            chk(16'h0, 16'(s14));
        end
        // Sleep and run options against driver enable and pump
        for (int m = 0; m < 4; m++) begin
            @(negedge clk_sys_in);
            {slp, run} = 2'(m);
            cap = ^2'(m);
            #1 chk(16'(m != 2), 16'(on));
            if (on === 1'b1) chk(16'(cap), 16'(pump));
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
